// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, reg_wr, lookup_valid, protection_fault, type_valid;
  logic [1:0] reg_sel;
  logic [2:0] reg_idx;
  logic [63:0] reg_wdata, reg_rdata;
  logic [35:0] lookup_addr;
  logic [7:0] type_out;
  int miscompares, checks, cycles;
  logic [7:0] good_t [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  logic [7:0] bad_t [4] = '{8'h02, 8'h03, 8'h07, 8'hFF};
  logic [1:0] bad_s [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [63:0] bad_d [7] = '{64'h0000_0000_0000_0100, 64'h0000_0010_0000_0000,
    64'h0000_0000_0000_0001, 64'h8000_0000_0000_0000, 64'h0000_0000_0000_0807,
    64'h0000_0000_0000_1804, 64'h0000_0000_0000_0002};
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
  memory_type_range_resolver dut (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_sel(reg_sel), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .protection_fault(protection_fault), .lookup_valid(lookup_valid),
    .lookup_addr(lookup_addr), .type_valid(type_valid), .type_out(type_out));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // cut a hang short well above the roughly 190 cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic wr(input logic [1:0] s, input logic [2:0] i, input logic [63:0] d,
                    input logic f);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_idx <= i;
    reg_wdata <= d;
    lookup_valid <= 1'b0;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
    `CHK(protection_fault, f)
    `CHK(type_valid, 1'b0)
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] i, input logic [63:0] e);
    @(posedge mclk);
    reg_sel <= s;
    reg_idx <= i;
    @(posedge mclk);
    #1;
    `CHK(reg_rdata, e)
  endtask
  // lookup answer is checked 1 ns after the clock edge that samples the address
  task automatic look(input logic [35:0] a, input logic [7:0] e);
    @(posedge mclk);
    lookup_valid <= 1'b1;
    lookup_addr <= a;
    @(posedge mclk);
    #1;
    `CHK(type_valid, 1'b1)
    `CHK(type_out, e)
  endtask
  initial begin
    {arst_n, reg_wr, lookup_valid, reg_sel, reg_idx, reg_wdata, lookup_addr} = '0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(2'h1, 3'h0, 64'h0);
    rd(2'h2, 3'h0, 64'h0);
    // clear every range field before any type is programmed
    for (int k = 0; k < 8; k++) begin
      wr(2'h0, 3'(k), 64'h0, 1'b0);
      wr(2'h1, 3'(k), 64'h0, 1'b0);
      wr(2'h3, 3'(k), 64'h0, 1'b0);
    end
    look(36'h0_0400_0000, 8'h00);
    wr(2'h2, 3'h0, 64'h0000_0000_0000_0804, 1'b0);
    look(36'h0_0000_0000, 8'h04);
    look(36'h0_0400_0000, 8'h04);
    wr(2'h0, 3'h0, 64'h0000_0000_0000_0006, 1'b0);
    wr(2'h1, 3'h0, 64'h0000_000F_FC00_0800, 1'b0);
    look(36'h0_03FF_FFFF, 8'h06);
    look(36'h0_0400_0000, 8'h04);
    wr(2'h0, 3'h1, 64'h0000_0000_0400_0000, 1'b0);
    wr(2'h1, 3'h1, 64'h0000_000F_FC00_0000, 1'b0);
    look(36'h0_0400_0000, 8'h04);
    wr(2'h1, 3'h1, 64'h0000_000F_FC00_0800, 1'b0);
    look(36'h0_0400_0000, 8'h00);
    wr(2'h0, 3'h2, 64'h0, 1'b0);
    wr(2'h1, 3'h2, 64'h0000_000F_FFC0_0800, 1'b0);
    look(36'h0_0010_0000, 8'h00);
    wr(2'h0, 3'h2, 64'h0000_0000_0000_0004, 1'b0);
    look(36'h0_0010_0000, 8'h00);
    // discontinuous mask: repeats every 256 MB
    wr(2'h0, 3'h4, 64'h0000_0000_0100_0001, 1'b0);
    wr(2'h1, 3'h4, 64'h0000_000F_0F00_0800, 1'b0);
    look(36'h0_1100_0000, 8'h01);
    look(36'h0_1200_0000, 8'h04);
    wr(2'h3, 3'h0, 64'h0505_0505_0505_0505, 1'b0);
    wr(2'h2, 3'h0, 64'h0000_0000_0000_0C04, 1'b0);
    look(36'h0_0000_0000, 8'h05);
    look(36'h0_0010_0000, 8'h00);
    wr(2'h2, 3'h0, 64'h0000_0000_0000_0404, 1'b0);
    look(36'h0_0000_0000, 8'h04);
    wr(2'h2, 3'h0, 64'h0000_0000_0000_0804, 1'b0);
    for (int k = 0; k < 7; k++) begin
      wr(bad_s[k], 3'h7, bad_d[k], 1'b1);
      rd(bad_s[k], 3'h7, (bad_s[k] == 2'h2) ? 64'h0000_0000_0000_0804 : 64'h0);
    end
    for (int k = 0; k < 5; k++) begin
      wr(2'h0, 3'h7, {56'h0, good_t[k]}, 1'b0);
      rd(2'h0, 3'h7, {56'h0, good_t[k]});
    end
    for (int k = 0; k < 4; k++) begin
      wr(2'h0, 3'h7, {56'h0, bad_t[k]}, 1'b1);
      rd(2'h0, 3'h7, 64'h6);
    end
    // second reset in mid-run: valid flags and global enable must drop again
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd(2'h1, 3'h1, 64'h0);
    rd(2'h0, 3'h7, 64'h0);
    look(36'h0_0400_0000, 8'h00);
    summarize();
  end
endmodule

// ===== verilog/memory_type_range_resolver.sv
// Contract
// - a pair counts only while mask bit 11 valid is set
// - writing a reserved bit of base or mask faults and leaves register unchanged
// - overlapping uncached/uncached or uncached/writeback resolves to uncached
// - enabled fixed range wins over any matching variable range
// - addresses outside a discontinuous mask take the default type
// - 24-bit base and mask fields get twelve zero bits appended below
// - with ranges globally disabled every access takes the default type
// - below 1 MByte with fixed ranges enabled, the fixed field type applies
// - exactly one matching pair gives that pair's base type field
// - no match at all gives the default type
// - reset clears all valid flags and the global enable
// - match when address and mask equals base and mask
// - only type codes 0,1,4,5,6 are legal; others fault
// - default reg bit 10 enables fixed, bit 11 enables all
// - base holds type 7:0 and base 35:12; mask holds mask 35:12
module memory_type_range_resolver (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register access port
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [2:0] reg_idx,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic protection_fault,
  // lookup port
  input wire logic lookup_valid,
  input wire logic [35:0] lookup_addr,
  output logic type_valid,
  output logic [7:0] type_out
);
  typedef struct packed {
    logic [7:0][63:0] base;
    logic [7:0][63:0] mask;
    logic [7:0][63:0] fixed;
    logic [63:0] deftype;
    logic [63:0] rdata;
    logic fault;
    logic tvalid;
    logic [7:0] mtype;
  } state_t;

  state_t s_q, s_d;

  function automatic logic legal_type(input logic [7:0] t);
    return t == range_pkg::type_uncached || t == range_pkg::type_write_combining ||
      t == range_pkg::type_write_through || t == range_pkg::type_write_protected ||
      t == range_pkg::type_writeback;
  endfunction

  function automatic logic [35:0] widen(input logic [63:0] r);
    return {r[range_pkg::addr_w-1:range_pkg::page_lsb], {range_pkg::page_lsb{1'b0}}};
  endfunction

  // fixed field per address; a simple page map of the first megabyte
  function automatic logic [7:0] fixed_type(input state_t s, input logic [35:0] a);
    logic [5:0] f;
    f = 6'(a[19:14]);
    return s.fixed[f[5:3]][f[2:0]*8 +: 8];
  endfunction

  logic [7:0] hit;
  logic any_uncached, only_uncached_writeback;
  logic [7:0] var_type;
  int nhit;

  always_comb begin
    // count every hit rather than take the first: overlaps must see all of them
    nhit = 0;
    any_uncached = 1'b0;
    only_uncached_writeback = 1'b1;
    var_type = range_pkg::type_uncached;
    for (int i = 0; i < range_pkg::num_pairs; i++) begin
      hit[i] = s_q.mask[i][range_pkg::pair_valid_bit] &&
        ((lookup_addr & widen(s_q.mask[i])) ==
         (widen(s_q.base[i]) & widen(s_q.mask[i])));
      if (hit[i]) begin
        nhit = nhit + 1;
        var_type = s_q.base[i][7:0];
        if (s_q.base[i][7:0] == range_pkg::type_uncached) any_uncached = 1'b1;
        else if (s_q.base[i][7:0] != range_pkg::type_writeback) only_uncached_writeback = 1'b0;
      end
    end
    // overlap: defined and undefined mixes both go uncached, keeps result deterministic
    if (nhit > 1) begin
      var_type = range_pkg::type_uncached;
    end
  end

  always_comb begin
    logic [63:0] wmask;
    logic bad;
    s_d = s_q;
    wmask = '0;
    bad = 1'b0;
    s_d.fault = 1'b0;
    s_d.tvalid = lookup_valid;
    unique case (reg_sel)
      range_pkg::sel_base: begin
        wmask = range_pkg::base_writable;
        bad = !legal_type(reg_wdata[7:0]);
        s_d.rdata = s_q.base[reg_idx];
      end
      range_pkg::sel_mask: begin
        wmask = range_pkg::mask_writable;
        s_d.rdata = s_q.mask[reg_idx];
      end
      range_pkg::sel_deftype: begin
        wmask = range_pkg::deftype_writable;
        bad = !legal_type(reg_wdata[7:0]);
        s_d.rdata = s_q.deftype;
      end
      range_pkg::sel_fixed: begin
        wmask = range_pkg::fixed_writable;
        // each byte is a type code of its own, so every byte is checked
        for (int k = 0; k < 8; k++) if (!legal_type(reg_wdata[k*8 +: 8])) bad = 1'b1;
        s_d.rdata = s_q.fixed[reg_idx];
      end
    endcase
    if (reg_wr) begin
      if ((reg_wdata & ~wmask) != 64'h0000_0000_0000_0000 || bad) begin
        s_d.fault = 1'b1;
      end else begin
        unique case (reg_sel)
          range_pkg::sel_base: s_d.base[reg_idx] = reg_wdata;
          range_pkg::sel_mask: s_d.mask[reg_idx] = reg_wdata;
          range_pkg::sel_deftype: s_d.deftype = reg_wdata;
          range_pkg::sel_fixed: s_d.fixed[reg_idx] = reg_wdata;
        endcase
      end
    end
    // precedence
    if (!s_q.deftype[range_pkg::global_enable_bit]) begin
      s_d.mtype = s_q.deftype[7:0];
    end else if (s_q.deftype[range_pkg::fixed_enable_bit] &&
                 lookup_addr < range_pkg::fixed_limit) begin
      s_d.mtype = fixed_type(s_q, lookup_addr);
    end else if (nhit > 0) begin
      s_d.mtype = var_type;
    end else begin
      s_d.mtype = s_q.deftype[7:0];
    end
  end

  // all state bits power up as zero; cheaper than leaving them unknown
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign protection_fault = s_q.fault;
  assign type_valid = s_q.tvalid;
  assign type_out = s_q.mtype;

  // all checks share the one clock; reset cancels any attempt in flight
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // register port: faults and clean writes
  reserved_fault_a: assert property (reg_wr && reg_sel == 2'h1 && reg_wdata[0]
    |=> protection_fault && s_q.mask == $past(s_q.mask))
    else $error("reserved write not faulted");
  bad_type_a: assert property (reg_wr && reg_sel == 2'h0
    && reg_wdata[7:0] == 8'h02 |=> protection_fault)
    else $error("illegal type accepted");
  deftype_type_a: assert property (reg_wr && reg_sel == 2'h2
    && reg_wdata[7:0] == 8'h07 |=> protection_fault && s_q.deftype == $past(s_q.deftype))
    else $error("illegal default type accepted");
  write_quiet_a: assert property (!reg_wr |=> !protection_fault)
    else $error("fault without write");
  mask_write_a: assert property (reg_wr && reg_sel == 2'h1
    && (reg_wdata & ~range_pkg::mask_writable) == 64'h0000_0000_0000_0000
    |=> !protection_fault && s_q.mask[$past(reg_idx)] == $past(reg_wdata))
    else $error("clean mask write lost");
  base_write_a: assert property (reg_wr && reg_sel == 2'h0
    && reg_wdata[7:0] == 8'h06
    && (reg_wdata & ~range_pkg::base_writable) == 64'h0000_0000_0000_0000
    |=> !protection_fault && s_q.base[$past(reg_idx)] == $past(reg_wdata))
    else $error("clean base write lost");

  // lookup path: precedence and latency
  disabled_default_a: assert property (!s_q.deftype[11]
    |=> type_out == $past(s_q.deftype[7:0]))
    else $error("disabled lookup not default");
  fixed_wins_a: assert property (s_q.deftype[11] && s_q.deftype[10]
    && lookup_addr[35:20] == 16'h0000 |=> type_out == $past(fixed_type(s_q, lookup_addr)))
    else $error("fixed precedence lost");
  fixed_off_a: assert property (s_q.deftype[11] && !s_q.deftype[10]
    && lookup_addr[35:20] == 16'h0000 && hit == 8'h00
    |=> type_out == $past(s_q.deftype[7:0]))
    else $error("disabled fixed range used");
  invalid_pair_a: assert property (s_q.mask[0][11] == 1'b0 |-> !hit[0])
    else $error("invalid pair matched");
  uncached_mix_a: assert property (s_q.deftype[11] && !s_q.deftype[10]
    && nhit > 1 && any_uncached && only_uncached_writeback
    |=> type_out == range_pkg::type_uncached)
    else $error("uncached overlap not resolved");
  overlap_uncached_a: assert property (s_q.deftype[11] && !s_q.deftype[10]
    && $countones(hit) > 1 |=> type_out == 8'h00)
    else $error("overlap not uncached");
  no_hit_a: assert property (s_q.deftype[11] && !s_q.deftype[10] && hit == 8'h00
    |=> type_out == $past(s_q.deftype[7:0]))
    else $error("miss not default");
  single_hit_a: assert property (s_q.deftype[11] && !s_q.deftype[10]
    && hit == 8'h01 |=> type_out == $past(s_q.base[0][7:0]))
    else $error("single hit wrong");
  latency_a: assert property (lookup_valid |=> type_valid)
    else $error("lookup latency wrong");
  idle_latency_a: assert property (!lookup_valid |=> !type_valid)
    else $error("answer without request");

  overlap_c: cover property (s_q.deftype[11] && $countones(hit) > 1);
  single_c: cover property (s_q.deftype[11] && $countones(hit) == 1);
  fault_c: cover property (protection_fault);
  fixed_c: cover property (s_q.deftype[11] && s_q.deftype[10] && lookup_addr < range_pkg::fixed_limit);
  disabled_c: cover property (!s_q.deftype[11] && s_q.mask[0][11] && lookup_valid);
endmodule

// ===== verilog/range_pkg.sv
package range_pkg;
  // memory type codes
  localparam logic [7:0] type_uncached = 8'h00;
  localparam logic [7:0] type_write_combining = 8'h01;
  localparam logic [7:0] type_write_through = 8'h04;
  localparam logic [7:0] type_write_protected = 8'h05;
  localparam logic [7:0] type_writeback = 8'h06;
  // geometry
  localparam int num_pairs = 8;
  localparam int num_fixed = 8;
  localparam int addr_w = 36;
  localparam int field_w = 24;
  localparam int page_lsb = 12;
  localparam int type_lsb = 0;
  localparam int type_w = 8;
  localparam int pair_valid_bit = 11;
  localparam int fixed_enable_bit = 10;
  localparam int global_enable_bit = 11;
  localparam logic [35:0] fixed_limit = 36'h0_0010_0000;
  // writable bits; everything else is reserved
  localparam logic [63:0] base_writable = 64'h0000_000F_FFFF_F0FF;
  localparam logic [63:0] mask_writable = 64'h0000_000F_FFFF_F800;
  localparam logic [63:0] deftype_writable = 64'h0000_0000_0000_0CFF;
  localparam logic [63:0] fixed_writable = 64'hFFFF_FFFF_FFFF_FFFF;
  // register select codes on the access port
  localparam logic [1:0] sel_base = 2'h0;
  localparam logic [1:0] sel_mask = 2'h1;
  localparam logic [1:0] sel_deftype = 2'h2;
  localparam logic [1:0] sel_fixed = 2'h3;
  localparam logic [63:0] reset_value = 64'h0000_0000_0000_0000;
endpackage
